// [shared/bie_consts.svh]
// Constants for the branch and increment execute block
// How it works
// - The absolute branch is two words: first word 1110 1111 with target bits 7..0, second word starting 1111 with target bits 19..8.
// - The branch loads the 20-bit target into program counter bits 20..1 and changes no flag.
// - The branch always takes two cycles, the counter written at the end of the first and the second a full no-operation.
// - The plain increment 0010 10da adds one to the file, writes the accumulator when d is 0 or the file when d is 1, and updates C, DC, N, OV and Z.
// - For both increments, access bit 0 selects the quick-access bank and access bit 1 forms the address from the bank select pointer and the file field.
// - With the extended set enabled, access bit 0 and file field at most 95 use indexed literal offset addressing.
// - The increment-skip 0011 11da increments and selects destination like the plain increment but leaves the flags alone.
// - A zero increment-skip result discards the fetched instruction and runs a no-operation cycle in its place; non-zero takes one cycle.
// - If the discarded instruction is two words, its second word is discarded too, three cycles in total.
`ifndef BIE_CONSTS_SVH
`define BIE_CONSTS_SVH
`define BIE_OP_BRANCH 8'hef
`define BIE_OP_WORD2 4'hf
`define BIE_OP_INC 6'h0a
`define BIE_OP_INCSZ 6'h0f
`define BIE_ILO_MAX 8'h5f
`define BIE_ACCESS_HI 4'hf
`define BIE_ACCESS_SPLIT 8'h80
`define BIE_FLAG_C 0
`define BIE_FLAG_DC 1
`define BIE_FLAG_Z 2
`define BIE_FLAG_OV 3
`define BIE_FLAG_N 4
`define BIE_Q1 2'h0
`define BIE_Q2 2'h1
`define BIE_Q3 2'h2
`define BIE_Q4 2'h3
`endif

// [shared/bie_pkg.sv]
// Types for the branch and increment execute block
package bie_pkg;
	typedef enum logic [1:0] {
		BIE_EXEC,
		BIE_BR_NOP,
		BIE_SKIP_NOP,
		BIE_SKIP_NOP2
	} bie_state_type;
endpackage

// [verilog/bie_exec.sv]
// Decode and execute of absolute branch, increment and increment-skip
`timescale 1ns/1ps
`include "bie_consts.svh"
module bie_exec (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Quarter-phase enable, one pulse per quarter cycle
	input wire logic q_en,
	// Instruction words
	input wire logic [15:0] instr,
	input wire logic [15:0] next_word,
	input wire logic next_is_two_word,
	// Configuration
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_pointer,
	input wire logic [11:0] index_base,
	// File memory read data
	input wire logic [7:0] file_rdata,
	// File memory port
	output logic [11:0] file_addr,
	output logic file_rd,
	output logic [7:0] file_wdata,
	output logic file_we,
	// Accumulator
	output logic [7:0] acc_wdata,
	output logic acc_we,
	// Status flags
	output logic [4:0] status_q,
	// Program counter and sequencing
	output logic [20:0] pc_q,
	output logic [1:0] qphase_q,
	output logic nop_cycle,
	output logic unknown_op
);
	bie_pkg::bie_state_type st_q, st_d;
	logic [1:0] qphase_d;
	logic [20:0] pc_d;
	logic [4:0] status_d;
	logic [7:0] opnd_q, opnd_d;
	logic [8:0] sum_q, sum_d;
	logic [11:0] addr_q, addr_d;
	logic [7:0] ffield;
	logic is_branch, is_inc, is_incsz, dest_file, acc_bit;
	logic [4:0] low_sum;
	logic ov;
	logic skip_take, skip_two;
	logic [20:0] pc_inc;

	// Field split of the one-word forms: d at bit 9, access at bit 8
	assign ffield = instr[7:0];
	assign dest_file = instr[9];
	assign acc_bit = instr[8];
	assign is_branch = instr[15:8] == `BIE_OP_BRANCH;
	assign is_inc = instr[15:10] == `BIE_OP_INC;
	assign is_incsz = instr[15:10] == `BIE_OP_INCSZ;
	assign nop_cycle = st_q != bie_pkg::BIE_EXEC;
	assign unknown_op = st_q == bie_pkg::BIE_EXEC &&
		!(is_branch || is_inc || is_incsz);

	// Operand address, computed every cycle but latched only in Q1
	// so a late change of bank or base cannot move a write in Q4
	always_comb begin
		addr_d = addr_q;
		if (!acc_bit && ext_set_en && ffield <= `BIE_ILO_MAX) begin
			addr_d = index_base + {4'h0, ffield};
		end else if (!acc_bit) begin
			// Low half near zero, high half at the top of the map
			addr_d = ffield < `BIE_ACCESS_SPLIT ? {4'h0, ffield} :
				{`BIE_ACCESS_HI, ffield};
		end else begin
			addr_d = {bank_select_pointer, ffield};
		end
	end

	// Sequencing group. Each q_en pulse moves one quarter phase:
	// Q1 latches the operand address, Q2 reads the file, Q3 adds one
	// and Q4 writes the result and advances the counter. The forced
	// no-operation states hold the core for whole cycles so that the
	// program counter never moves in the middle of a dropped word.
	always_comb begin
		st_d = st_q;
		qphase_d = qphase_q;
		pc_d = pc_q;
		opnd_d = opnd_q;
		sum_d = sum_q;
		file_addr = addr_q;
		file_rd = 1'b0;
		file_we = 1'b0;
		file_wdata = sum_q[7:0];
		acc_we = 1'b0;
		acc_wdata = sum_q[7:0];
		if (q_en) begin
			qphase_d = qphase_q + 2'h1;
			unique case (st_q)
				bie_pkg::BIE_EXEC: begin
					unique case (qphase_q)
						`BIE_Q1: ;
						`BIE_Q2: begin
							if (is_inc || is_incsz) begin
								file_addr = addr_d;
								file_rd = 1'b1;
								opnd_d = file_rdata;
							end
						end
						`BIE_Q3: begin
							sum_d = {1'b0, opnd_q} + 9'h001;
						end
						`BIE_Q4: begin
							if (is_branch) begin
								// Target fetched with the second word
								pc_d = {next_word[11:0], ffield, 1'b0};
								// Two cycles always, whatever the second word
								st_d = bie_pkg::BIE_BR_NOP;
							end else if (is_inc || is_incsz) begin
								file_addr = addr_q;
								file_we = dest_file;
								acc_we = !dest_file;
								pc_d = pc_inc;
								if (skip_take) begin
									st_d = skip_two ?
										bie_pkg::BIE_SKIP_NOP2 :
										bie_pkg::BIE_SKIP_NOP;
								end
							end else begin
								pc_d = pc_inc;
							end
						end
					endcase
				end
				bie_pkg::BIE_BR_NOP: begin
					if (qphase_q == `BIE_Q4) begin
						st_d = bie_pkg::BIE_EXEC;
					end
				end
				bie_pkg::BIE_SKIP_NOP: begin
					if (qphase_q == `BIE_Q4) begin
						pc_d = pc_inc;
						st_d = bie_pkg::BIE_EXEC;
					end
				end
				bie_pkg::BIE_SKIP_NOP2: begin
					if (qphase_q == `BIE_Q4) begin
						pc_d = pc_inc;
						st_d = bie_pkg::BIE_SKIP_NOP;
					end
				end
			endcase
		end
	end

	// Flag group; the skip form and the branch leave every flag alone
	always_comb begin
		status_d = status_q;
		// Half carry is the carry out of the low nibble
		low_sum = {1'b0, opnd_q[3:0]} + 5'h01;
		// Adding one overflows only from the largest positive value
		ov = opnd_q == 8'h7f;
		if (q_en && st_q == bie_pkg::BIE_EXEC && qphase_q == `BIE_Q4 &&
			is_inc) begin
			status_d[`BIE_FLAG_C] = sum_q[8];
			status_d[`BIE_FLAG_DC] = low_sum[4];
			status_d[`BIE_FLAG_Z] = sum_q[7:0] == 8'h00;
			status_d[`BIE_FLAG_OV] = ov;
			status_d[`BIE_FLAG_N] = sum_q[7];
		end
	end

	// Skip decision from the registered sum, so it is settled by Q4
	always_comb begin
		skip_take = 1'b0;
		skip_two = 1'b0;
		if (is_incsz && sum_q[7:0] == 8'h00) begin
			skip_take = 1'b1;
			// A two-word victim costs a second dropped cycle
			skip_two = next_is_two_word;
		end
	end

	// Shared step for every sequential advance of the counter
	bie_pc_step #(
		.W(21)
	) u_pc_step (
		.cur(pc_q),
		.nxt(pc_inc)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= bie_pkg::BIE_EXEC;
			qphase_q <= 2'h0;
			pc_q <= 21'h000000;
			status_q <= 5'h00;
			opnd_q <= 8'h00;
			sum_q <= 9'h000;
			addr_q <= 12'h000;
		end else begin
			st_q <= st_d;
			qphase_q <= qphase_d;
			pc_q <= pc_d;
			status_q <= status_d;
			opnd_q <= opnd_d;
			sum_q <= sum_d;
			if (q_en && qphase_q == `BIE_Q1) begin
				addr_q <= addr_d;
			end
		end
	end
endmodule

// Fixed step adder for the program counter; wraps at the top of the map
module bie_pc_step #(
	parameter int W = 21
) (
	// Count in
	input wire logic [W-1:0] cur,
	// Count out
	output logic [W-1:0] nxt
);
	// One program word is two bytes, so the step is always two
	assign nxt = cur + W'(2);
endmodule

// [testbench/bie_exec_properties.sv]
// Assertions for the branch and increment execute block
`timescale 1ns/1ps
module bie_exec_properties (
	// Inputs
	input logic mclk, rst_n, q_en, ext_set_en, next_is_two_word,
	input logic [15:0] instr, next_word,
	input logic [3:0] bank_select_pointer,
	input logic [11:0] index_base,
	// Outputs
	input logic [11:0] file_addr,
	input logic file_rd, file_we, acc_we, nop_cycle,
	input logic [7:0] file_wdata, acc_wdata,
	input logic [4:0] status_q,
	input logic [20:0] pc_q,
	input logic [1:0] qphase_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_br;
		q_en && qphase_q == 2'h3 && instr[15:8] == 8'hef && !nop_cycle;
	endsequence
	sequence s_sk;
		q_en && (file_we || acc_we) && instr[15:10] == 6'h0f;
	endsequence
	property p_wr; q_en && (file_we || acc_we) |-> qphase_q == 2'h3 &&
		file_we == instr[9] && file_we != acc_we; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_bank; file_rd && instr[8] |->
		file_addr == {bank_select_pointer, instr[7:0]}; endproperty
	a_bank: assert property (p_bank) else $error("bank");
	property p_ilo; file_rd && ext_set_en && !instr[8] && instr[7:0] <= 8'h5f
		|-> file_addr == index_base + {4'h0, instr[7:0]}; endproperty
	a_ilo: assert property (p_ilo) else $error("indexed");
	property p_br_pc; s_br |=>
		pc_q == {$past(next_word[11:0]), $past(instr[7:0]), 1'b0}; endproperty
	a_br_pc: assert property (p_br_pc) else $error("target");
	property p_br_flag; s_br |=> $stable(status_q); endproperty
	a_br_flag: assert property (p_br_flag) else $error("flags");
	property p_br_nop; s_br |=> nop_cycle; endproperty
	a_br_nop: assert property (p_br_nop) else $error("nop");
	property p_sk_flag; s_sk |=> $stable(status_q); endproperty
	a_sk_flag: assert property (p_sk_flag) else $error("flags");
	property p_sk_nop; s_sk ##0 (file_we ? file_wdata : acc_wdata) == 8'h00
		|=> nop_cycle; endproperty
	a_sk_nop: assert property (p_sk_nop) else $error("skip");
	property p_sk_two; s_sk ##0 (file_we ? file_wdata : acc_wdata) == 8'h00
		&& next_is_two_word |=> nop_cycle [*8]; endproperty
	a_sk_two: assert property (p_sk_two) else $error("skip two");
endmodule
bind bie_exec bie_exec_properties u_props (.*);

// [testbench/bie_exec_test.sv]
// Scenario bench for the branch and increment execute block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %0t %h %h", $time, a, e); end end
module bie_exec_test;
	logic mclk = 0, rst_n = 0, q_en = 1, two = 0, ext = 0;
	logic [15:0] instr = 0;
	logic [11:0] fa, addr;
	logic [7:0] rd = 0, fw, aw, wd;
	logic [4:0] st, s;
	logic [20:0] pc, p;
	logic [1:0] wr;
	logic fr, fwe, awe, nop;
	int n_errors = 0, total_checks = 0;
	always #12.5 mclk = ~mclk;
	bie_exec dut (.mclk(mclk), .rst_n(rst_n), .q_en(q_en), .instr(instr),
		.next_word(16'hf567), .next_is_two_word(two), .ext_set_en(ext),
		.bank_select_pointer(4'h3), .index_base(12'h300), .file_rdata(rd),
		.file_addr(fa), .file_rd(fr), .file_wdata(fw), .file_we(fwe),
		.acc_wdata(aw), .acc_we(awe), .status_q(st), .pc_q(pc),
		.qphase_q(), .nop_cycle(nop), .unknown_op());
	// One instruction cycle; address taken in Q2, write strobes in Q4
	task automatic run(input logic [15:0] i, input logic [7:0] r);
		instr = i;
		rd = r;
		@(negedge mclk);
		addr = fa;
		repeat (2) @(negedge mclk);
		wr = {fwe, awe};
		wd = fwe ? fw : aw;
		@(negedge mclk);
	endtask
	task t_inc;
		p = pc;
		run(16'h2910, 8'hff);
		`CHK(addr, 12'h310)
		`CHK({wr, wd}, 10'h100)
		`CHK({st[2:0], pc}, {3'h7, p + 21'h2})
		run(16'h2a7f, 8'h7f);
		`CHK({addr, wr, wd}, {12'h07f, 2'h2, 8'h80})
		`CHK(st, 5'h1a)
		ext = 1;
		run(16'h2820, 8'h01);
		`CHK(addr, 12'h320)
		run(16'h2890, 8'h01);
		`CHK(addr, 12'hf90)
		ext = 0;
		$display("increment done");
	endtask
	task t_skip;
		s = st;
		two = 1;
		run(16'h3e40, 8'hff);
		instr = 16'h0;
		`CHK({wr, wd, st}, {10'h200, s})
		`CHK(nop, 1'b1)
		repeat (4) @(negedge mclk);
		`CHK(nop, 1'b1)
		repeat (4) @(negedge mclk);
		`CHK(nop, 1'b0)
		two = 0;
		run(16'h3c40, 8'h05);
		`CHK({wr, wd, nop}, 11'h20c)
		$display("skip done");
	endtask
	task t_br;
		s = st;
		run(16'hef34, 8'h00);
		instr = 16'h0;
		`CHK(pc, {12'h567, 8'h34, 1'b0})
		`CHK({st, nop}, {s, 1'b1})
		repeat (4) @(negedge mclk);
		`CHK(nop, 1'b0)
		$display("branch done");
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		rst_n = 1;
		t_inc;
		t_skip;
		t_br;
		wrap_up;
	end
	initial begin
		#20000;
		n_errors++;
		wrap_up;
	end
endmodule
